// file: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        ref_clk_i;
	logic        arst_n_i;
	logic        hsel_i;
	logic [31:0] haddr_i;
	logic [1:0]  htrans_i;
	logic        hwrite_i;
	logic [2:0]  hsize_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        done;
	logic        valid;
	logic        tr;
	logic        bc;
	logic [4:0]  sa;
	logic [15:0] ctrl_word_o;
	logic        ptr_o;
	logic        pp_o;
	logic        busy_o;
	logic        irq_o;
	logic        rd_pend;
	logic [31:0] rs;
	logic [31:0] exp_q[$];
	int          fail_count;
	int          n_compared;

	tmc_ctrl_word i_dut (
		.ref_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o(), .cmd_done_i(done), .cmd_valid_i(valid),
		.cmd_tr_i(tr), .cmd_subaddr_i(sa), .cmd_broadcast_seen_flag_i(bc), .ctrl_word_o,
		.second_pointer_select_o(ptr_o), .pingpong_active_o(pp_o),
		.make_busy_o(busy_o), .irq_o
	);
	tmc_cmd_src i_src (
		.clk_i(ref_clk_i), .done_o(done), .valid_o(valid), .tr_o(tr),
		.sa_o(sa), .broadcast_seen_flag_o(bc)
	);

	// ------------------------------------------
	// Helpers
	// ------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Bounded wait for hready at a rising edge
	task automatic hwait();
		int n;
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk_i);
			if (hreadyout_o === 1'b1) break;
		end
		if (n == 40) begin
			fail_count++;
			results();
		end
	endtask

	// One word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr_i  <= {24'h0, a};
		hwrite_i <= w;
		htrans_i <= 2'h2;
		hwait();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		rd_pend  <= !w;
		hwait();
		rd_pend  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic cmd(input logic v, input logic t, input logic [4:0] s,
		input logic b);
		rs = xs(rs);
		i_src.issue(v, t, s, b, rs[2:0]);
	endtask

	task automatic rst();
		arst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
	endtask

	// Read data against the oldest expectation
	always @(posedge ref_clk_i) begin
		if (rd_pend === 1'b1 && hreadyout_o === 1'b1 && exp_q.size() > 0) begin
			check("hrdata", hrdata_o, exp_q.pop_front());
		end
	end

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fail_count++;
		results();
	end

	// ------------------------------------------
	// Main sequence
	// ------------------------------------------
	initial begin
		{arst_n_i, hwrite_i, htrans_i, haddr_i, hwdata_i, rd_pend} = '0;
		hsel_i  = 1'b1;
		hsize_i = 3'h2;
		rs      = 32'h37;
		fail_count = 0;
		n_compared = 0;
		repeat (10) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		rd(tmc_pkg::OFF_CTRL, 32'h0);
		rd(tmc_pkg::OFF_STAT, 32'h0);
		rs = xs(rs);
		bus(1'b1, tmc_pkg::OFF_INDEX, rs);
		rd(tmc_pkg::OFF_INDEX, {24'h0, rs[7:0]});
		bus(1'b1, 8'h1c, rs);
		rd(8'h1c, 32'h0);
		// Device bits refuse host data, unused bits stay clear
		bus(1'b1, tmc_pkg::OFF_CTRL, 32'hffff);
		rd(tmc_pkg::OFF_CTRL, 32'hf00c);
		check("busy", {31'h0, busy_o}, 32'h1);
		bus(1'b1, tmc_pkg::OFF_CFG, 32'h2);
		bus(1'b1, tmc_pkg::OFF_CTRL, 32'h0);
		rd(tmc_pkg::OFF_CFG, 32'h2);
		rd(tmc_pkg::OFF_CTRL, 32'h4);
		rst();
		rd(tmc_pkg::OFF_CTRL, 32'h0);
		// Host sets up the word before execution starts
		bus(1'b1, tmc_pkg::OFF_CFG, 32'h1);
		bus(1'b1, tmc_pkg::OFF_CTRL, 32'he000);
		bus(1'b1, tmc_pkg::OFF_GEN, 32'h7);
		bus(1'b1, tmc_pkg::OFF_MASK, 32'h7);
		bus(1'b1, tmc_pkg::OFF_INDEX, 32'h2);
		bus(1'b1, tmc_pkg::OFF_CFG, 32'h3);
		cmd(1'b1, 1'b1, 5'h05, 1'b0);
		cmd(1'b1, 1'b0, 5'h00, 1'b0);
		cmd(1'b0, 1'b1, 5'h1f, 1'b0);
		rd(tmc_pkg::OFF_STAT, 32'h0);
		cmd(1'b1, 1'b1, 5'h1f, 1'b1);
		rd(tmc_pkg::OFF_CTRL, 32'hea00);
		rd(tmc_pkg::OFF_CTRL, 32'he200);
		rd(tmc_pkg::OFF_STAT, 32'h6);
		check("irq", {31'h0, irq_o}, 32'h1);
		cmd(1'b1, 1'b1, 5'h00, 1'b0);
		rd(tmc_pkg::OFF_INDEX, 32'h0);
		rd(tmc_pkg::OFF_STAT, 32'h7);
		rd(tmc_pkg::OFF_LOG, 32'h0003_0002);
		bus(1'b1, tmc_pkg::OFF_STAT, 32'h7);
		rd(tmc_pkg::OFF_STAT, 32'h0);
		check("irq", {31'h0, irq_o}, 32'h0);
		bus(1'b1, tmc_pkg::OFF_MASK, 32'h0);
		cmd(1'b1, 1'b1, 5'h00, 1'b0);
		rd(tmc_pkg::OFF_STAT, 32'h2);
		check("irq", {31'h0, irq_o}, 32'h0);
		bus(1'b1, tmc_pkg::OFF_CFG, 32'hb);
		rd(tmc_pkg::OFF_CFG, 32'h3);
		rd(tmc_pkg::OFF_CTRL, 32'he000);
		// Ping-pong words written while the terminal is enabled
		rst();
		bus(1'b1, tmc_pkg::OFF_CFG, 32'h1);
		bus(1'b1, tmc_pkg::OFF_CTRL, 32'h4);
		bus(1'b1, tmc_pkg::OFF_CFG, 32'h3);
		rd(tmc_pkg::OFF_CFG, 32'h3);
		rd(tmc_pkg::OFF_CTRL, 32'h104);
		cmd(1'b1, 1'b1, 5'h00, 1'b0);
		rd(tmc_pkg::OFF_CTRL, 32'hd04);
		check("ptr", {30'h0, ptr_o, pp_o}, 32'h3);
		bus(1'b1, tmc_pkg::OFF_CTRL, 32'hc);
		rd(tmc_pkg::OFF_CFG, 32'h3);
		rd(tmc_pkg::OFF_CTRL, 32'h40c);
		cmd(1'b1, 1'b1, 5'h1f, 1'b0);
		rd(tmc_pkg::OFF_CTRL, 32'hc0c);
		bus(1'b1, tmc_pkg::OFF_CTRL, 32'h4);
		rd(tmc_pkg::OFF_CFG, 32'h3);
		rd(tmc_pkg::OFF_CTRL, 32'h504);
		bus(1'b1, tmc_pkg::OFF_CFG, 32'h7);
		cmd(1'b1, 1'b1, 5'h00, 1'b0);
		rd(tmc_pkg::OFF_CTRL, 32'hd04);
		results();
	end
endmodule

bind tmc_ctrl_word tmc_ctrl_word_props i_props (
	.ref_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
	.hsize_i, .hwdata_i, .hready_i, .cmd_done_i, .cmd_valid_i, .cmd_tr_i,
	.cmd_subaddr_i, .cmd_broadcast_seen_flag_i, .ctrl_word_o, .second_pointer_select_o,
	.pingpong_active_o, .make_busy_o
);
`default_nettype wire

// file: dv/tmc_cmd_src.sv
`timescale 1ns/1ns
`default_nettype none
// Far side: protocol engine reporting finished commands
module tmc_cmd_src (
	input  wire logic       clk_i,
	output logic            done_o,
	output logic            valid_o,
	output logic            tr_o,
	output logic      [4:0] sa_o,
	output logic            broadcast_seen_flag_o
);
	// Idle at time zero
	initial begin
		done_o = 1'b0;
		{valid_o, tr_o, sa_o, broadcast_seen_flag_o} = 8'h5a;
	end

	// One completion pulse after dly idle cycles plus one; the extra edge
	// keeps the strobe from falling and rising within one time step
	task automatic issue(input logic v, input logic t, input logic [4:0] s,
		input logic b, input logic [2:0] dly);
		repeat (int'(dly) + 1) @(posedge clk_i);
		done_o <= 1'b1;
		{valid_o, tr_o, sa_o, broadcast_seen_flag_o} <= {v, t, s, b};
		@(posedge clk_i);
		// Qualifiers mean nothing off the pulse, so scramble them
		done_o <= 1'b0;
		{valid_o, tr_o, sa_o, broadcast_seen_flag_o} <= ~{v, t, s, b};
	endtask
endmodule
`default_nettype wire

// file: dv/tmc_ctrl_word_props.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the transmit mode control word
module tmc_ctrl_word_props (
	input wire logic        ref_clk_i,
	input wire logic        arst_n_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic        cmd_done_i,
	input wire logic        cmd_valid_i,
	input wire logic        cmd_tr_i,
	input wire logic [4:0]  cmd_subaddr_i,
	input wire logic        cmd_broadcast_seen_flag_i,
	input wire logic [15:0] ctrl_word_o,
	input wire logic        second_pointer_select_o,
	input wire logic        pingpong_active_o,
	input wire logic        make_busy_o
);
	logic acc;
	logic mc;

	// Accepted word transfer, and a mode code command
	assign acc = hsel_i && htrans_i[1] && hready_i && hsize_i == 3'h2;
	assign mc  = cmd_tr_i && (cmd_subaddr_i == tmc_pkg::SA_MC_LO ||
		cmd_subaddr_i == tmc_pkg::SA_MC_HI);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	// ------------------------------------------
	// Bus steps
	// ------------------------------------------
	sequence s_rd_ctrl;
		acc && !hwrite_i && haddr_i[7:0] == tmc_pkg::OFF_CTRL ##1 !cmd_done_i;
	endsequence
	sequence s_wr_ctrl;
		acc && hwrite_i && haddr_i[7:0] == tmc_pkg::OFF_CTRL ##1 1'b1;
	endsequence
	sequence s_soft_reset_cmd;
		acc && hwrite_i && haddr_i[7:0] == tmc_pkg::OFF_CFG ##1 hwdata_i[3];
	endsequence

	// ------------------------------------------
	// Properties
	// ------------------------------------------
	property p_unused;
		ctrl_word_o[7:4] == 4'h0 && ctrl_word_o[1:0] == 2'h0;
	endproperty
	property p_mirror;
		second_pointer_select_o == ctrl_word_o[10] &&
		pingpong_active_o == ctrl_word_o[8] && make_busy_o == ctrl_word_o[12];
	endproperty
	property p_rd_clear;
		s_rd_ctrl |=> !ctrl_word_o[11];
	endproperty
	property p_host_bits;
		s_wr_ctrl |=> {ctrl_word_o[15:12], ctrl_word_o[3]} ==
			{$past(hwdata_i[15:12]), $past(hwdata_i[3])};
	endproperty
	property p_soft_reset_cmd;
		s_soft_reset_cmd |=> ##[0:1] ctrl_word_o[11:9] == 3'h0;
	endproperty
	property p_non_mode;
		cmd_done_i && !mc && !ctrl_word_o[11] |=> !ctrl_word_o[11];
	endproperty
	property p_bc_rise;
		$rose(ctrl_word_o[9]) |->
			$past(cmd_done_i && cmd_valid_i && mc && cmd_broadcast_seen_flag_i);
	endproperty
	property p_acc_rise;
		$rose(ctrl_word_o[11]) |-> $past(cmd_done_i && cmd_valid_i && mc);
	endproperty
	property p_ptr_rise;
		$rose(ctrl_word_o[10]) |->
			$past(cmd_done_i && ctrl_word_o[8] && ctrl_word_o[2]);
	endproperty

	a_unused: assert property (p_unused)
		else $error("unused control bits set");
	a_mirror: assert property (p_mirror)
		else $error("status outputs differ from word");
	a_rd_clear: assert property (p_rd_clear)
		else $error("accessed flag kept after read");
	a_host_bits: assert property (p_host_bits)
		else $error("host bits not written");
	a_soft_reset_cmd: assert property (p_soft_reset_cmd)
		else $error("soft reset left flags set");
	a_non_mode: assert property (p_non_mode)
		else $error("non mode command touched word");
	a_bc_rise: assert property (p_bc_rise)
		else $error("broadcast flag without broadcast");
	a_acc_rise: assert property (p_acc_rise)
		else $error("accessed flag without command");
	a_ptr_rise: assert property (p_ptr_rise)
		else $error("pointer toggled while inactive");
endmodule
`default_nettype wire

// file: hw/tmc_ahb_slave.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_ahb_slave (
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	tmc_regbus_if.front      bus
);
	// ------------------------------------------------------------
	// Address phase capture
	// ------------------------------------------------------------
	logic        acc;
	logic        wr_q, wr_d;
	logic [7:0]  wa_q, wa_d;
	logic [31:0] rd_q, rd_d;

	// Only whole-word transfers are taken; others complete harmlessly
	assign acc = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2);

	always_comb begin
		wr_d = acc & hwrite_i;
		wa_d = acc ? haddr_i[7:0] : wa_q;
		rd_d = (acc & ~hwrite_i) ? bus.rdata : rd_q;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			rd_q <= 32'h0000_0000;
		end else begin
			wr_q <= wr_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rd_q;
	assign bus.rd      = acc & ~hwrite_i;
	assign bus.raddr   = haddr_i[7:0];
	assign bus.wr      = wr_q;
	assign bus.waddr   = wa_q;
	assign bus.wdata   = hwdata_i;
endmodule
`default_nettype wire

// file: hw/tmc_ctrl_word.sv
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tmc_ctrl_word #(
	parameter int unsigned INDEX_W = 8,
	parameter int unsigned LOG_W   = 8
) (
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        cmd_done_i,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_tr_i,
	input  wire logic [4:0]  cmd_subaddr_i,
	input  wire logic        cmd_broadcast_seen_flag_i,
	output logic      [15:0] ctrl_word_o,
	output logic             second_pointer_select_o,
	output logic             pingpong_active_o,
	output logic             make_busy_o,
	output logic             irq_o
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (INDEX_W < 1 || INDEX_W > 16) begin : g_chk
		$error("tmc_ctrl_word: INDEX_W out of range");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_modecode(input logic       tr,
	                                     input logic [4:0] sa);
		return tr && (sa == tmc_pkg::SA_MC_LO ||
		              sa == tmc_pkg::SA_MC_HI);
	endfunction

	function automatic logic hit(input logic [7:0] a,
	                             input logic [7:0] off);
		return a == off;
	endfunction

	// ------------------------------------------------------------
	// Bus front end and interrupt block
	// ------------------------------------------------------------
	tmc_regbus_if bus ();

	tmc_ahb_slave u_slave (
		.ref_clk_i   (ref_clk_i),
		.arst_n_i    (arst_n_i),
		.hsel_i      (hsel_i),
		.haddr_i     (haddr_i),
		.htrans_i    (htrans_i),
		.hwrite_i    (hwrite_i),
		.hsize_i     (hsize_i),
		.hwdata_i    (hwdata_i),
		.hready_i    (hready_i),
		.hrdata_o    (hrdata_o),
		.hreadyout_o (hreadyout_o),
		.hresp_o     (hresp_o),
		.bus         (bus.front)
	);

	localparam int N = tmc_pkg::NUM_EV;

	logic [N-1:0]     ev;
	logic [N-1:0]     status;
	logic [N-1:0]     mask;
	logic [LOG_W-1:0] log_cnt;
	logic [N-1:0]     log_last;
	logic             wr_stat;
	logic             wr_mask;

	assign wr_stat = bus.wr && hit(bus.waddr, tmc_pkg::OFF_STAT);
	assign wr_mask = bus.wr && hit(bus.waddr, tmc_pkg::OFF_MASK);

	tmc_irq #(
		.LOG_W (LOG_W)
	) u_irq (
		.ref_clk_i  (ref_clk_i),
		.arst_n_i   (arst_n_i),
		.ev_i       (ev),
		.stat_wr_i  (wr_stat),
		.mask_wr_i  (wr_mask),
		.wdata_i    (bus.wdata[N-1:0]),
		.status_o   (status),
		.mask_o     (mask),
		.log_cnt_o  (log_cnt),
		.log_last_o (log_last),
		.irq_o      (irq_o)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0]        ctrl_q, ctrl_d;
	logic [2:0]         cfg_q, cfg_d;
	logic [N-1:0]       gen_q, gen_d;
	logic [INDEX_W-1:0] idx_q, idx_d;
	logic               arm_q, arm_d;
	logic               rdc_q, rdc_d;

	logic               exec;
	logic               mc_done;
	logic               soft_reset_cmd;
	logic               wr_ctrl;
	logic [15:0]        wmask;
	tmc_pkg::tmc_mode_t mode;

	assign exec = cfg_q[tmc_pkg::C_EXEC];

	assign mc_done = cmd_done_i && cmd_valid_i && exec &&
	                 is_modecode(cmd_tr_i, cmd_subaddr_i);

	assign wr_ctrl = bus.wr && hit(bus.waddr, tmc_pkg::OFF_CTRL);
	assign soft_reset_cmd    = bus.wr && hit(bus.waddr, tmc_pkg::OFF_CFG) &&
	                 bus.wdata[tmc_pkg::C_SOFT_RESET_CMD];

	always_comb begin
		if (cfg_q[tmc_pkg::C_SIMPLIFIED_MODECODE_HANDLING]) begin
			mode = tmc_pkg::TMC_MODE_SIMPLE;
		end else if (ctrl_q[tmc_pkg::B_PINGPONG_SELECT]) begin
			mode = tmc_pkg::TMC_MODE_PINGPONG;
		end else begin
			mode = tmc_pkg::TMC_MODE_INDEXED;
		end
	end

	// bit 2 writable only while idle
	// host mask never covers bits 8-11
	assign wmask = tmc_pkg::HOST_ANY_MASK |
	               (exec ? 16'h0000 : tmc_pkg::HOST_IDLE_MASK);

	// ------------------------------------------------------------
	// Interrupt events
	// ------------------------------------------------------------
	always_comb begin
		ev = '0;
		ev[tmc_pkg::EV_IXZ] = mc_done &&
			mode == tmc_pkg::TMC_MODE_INDEXED &&
			idx_q == INDEX_W'(1) &&
			ctrl_q[tmc_pkg::B_IXZ_EN] && gen_q[tmc_pkg::EV_IXZ];
		ev[tmc_pkg::EV_ACC] = mc_done &&
			ctrl_q[tmc_pkg::B_ACC_EN] && gen_q[tmc_pkg::EV_ACC];
		ev[tmc_pkg::EV_BC] = mc_done && cmd_broadcast_seen_flag_i &&
			ctrl_q[tmc_pkg::B_BC_EN] && gen_q[tmc_pkg::EV_BC];
	end

	// ------------------------------------------------------------
	// Control word next state; later steps override earlier ones
	// ------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		cfg_d  = cfg_q;
		gen_d  = gen_q;
		idx_d  = idx_q;
		arm_d  = arm_q;
		rdc_d  = bus.rd && hit(bus.raddr, tmc_pkg::OFF_CTRL);

		// Host writes to side registers
		if (bus.wr && hit(bus.waddr, tmc_pkg::OFF_CFG)) begin
			cfg_d = bus.wdata[2:0];
		end
		if (bus.wr && hit(bus.waddr, tmc_pkg::OFF_GEN)) begin
			gen_d = bus.wdata[N-1:0];
		end
		if (bus.wr && hit(bus.waddr, tmc_pkg::OFF_INDEX)) begin
			idx_d = bus.wdata[INDEX_W-1:0];
		end

		// Host write to the word itself
		if (wr_ctrl) begin
			ctrl_d = (ctrl_q & ~wmask) | (bus.wdata[15:0] & wmask);
			// a write while disabled disarms the acknowledge
			arm_d  = cfg_q[tmc_pkg::C_TFE];
		end

		// clear accessed flag once read data has gone out
		if (rdc_q) begin
			ctrl_d[tmc_pkg::B_DESCRIPTOR_ACCESSED_FLAG] = 1'b0;
		end

		// device updates come after host writes
		if (exec) begin
			case (mode)
			tmc_pkg::TMC_MODE_PINGPONG: begin
				// suspend handshake on the active flag
				ctrl_d[tmc_pkg::B_PINGPONG_ACTIVE_FLAG] = arm_q &&
					!ctrl_q[tmc_pkg::B_PINGPONG_SUSPEND_REQUEST];
			end
			tmc_pkg::TMC_MODE_INDEXED: begin
				ctrl_d[tmc_pkg::B_PINGPONG_ACTIVE_FLAG] = 1'b0;
			end
			default: begin
				ctrl_d[tmc_pkg::B_PINGPONG_ACTIVE_FLAG] = ctrl_q[tmc_pkg::B_PINGPONG_ACTIVE_FLAG];
			end
			endcase
		end

		if (mc_done) begin
			// device maintains status bits while executing
			ctrl_d[tmc_pkg::B_DESCRIPTOR_ACCESSED_FLAG] = 1'b1;
			if (cmd_broadcast_seen_flag_i) begin
				ctrl_d[tmc_pkg::B_BROADCAST_SEEN_FLAG] = 1'b1;
			end
			case (mode)
			tmc_pkg::TMC_MODE_PINGPONG: begin
				// without acknowledge the same buffer is reused
				if (ctrl_q[tmc_pkg::B_PINGPONG_ACTIVE_FLAG]) begin
					ctrl_d[tmc_pkg::B_DPB] = ~ctrl_q[tmc_pkg::B_DPB];
				end
			end
			tmc_pkg::TMC_MODE_INDEXED: begin
				// Index stops at zero, it never wraps
				if (idx_q != '0) begin
					idx_d = idx_q - INDEX_W'(1);
				end
			end
			default: begin
				idx_d = idx_d;
			end
			endcase
		end

		// soft reset clears only three flags
		if (soft_reset_cmd) begin
			ctrl_d[tmc_pkg::B_DESCRIPTOR_ACCESSED_FLAG]  = 1'b0;
			ctrl_d[tmc_pkg::B_DPB]   = 1'b0;
			ctrl_d[tmc_pkg::B_BROADCAST_SEEN_FLAG] = 1'b0;
		end

		ctrl_d = ctrl_d & tmc_pkg::USED_MASK;
	end

	// master reset clears the whole word
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= tmc_pkg::CTRL_RST;
			cfg_q  <= tmc_pkg::CFG_RST;
			gen_q  <= tmc_pkg::EV_RST;
			idx_q  <= '0;
			arm_q  <= 1'b0;
			rdc_q  <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			cfg_q  <= cfg_d;
			gen_q  <= gen_d;
			idx_q  <= idx_d;
			arm_q  <= arm_d;
			rdc_q  <= rdc_d;
		end
	end

	// ------------------------------------------------------------
	// Read mux; unmapped offsets read as zero
	// ------------------------------------------------------------
	always_comb begin
		bus.rdata = 32'h0000_0000;
		case (bus.raddr)
		tmc_pkg::OFF_CTRL:  bus.rdata[15:0] = ctrl_q;
		tmc_pkg::OFF_CFG:   bus.rdata[2:0] = cfg_q;
		tmc_pkg::OFF_GEN:   bus.rdata[N-1:0] = gen_q;
		tmc_pkg::OFF_STAT:  bus.rdata[N-1:0] = status;
		tmc_pkg::OFF_MASK:  bus.rdata[N-1:0] = mask;
		tmc_pkg::OFF_INDEX: bus.rdata[INDEX_W-1:0] = idx_q;
		tmc_pkg::OFF_LOG: begin
			bus.rdata[LOG_W-1:0] = log_cnt;
			bus.rdata[16+N-1:16] = log_last;
		end
		default:            bus.rdata = 32'h0000_0000;
		endcase
	end

	// Outputs straight from flip-flops
	assign ctrl_word_o             = ctrl_q;
	assign second_pointer_select_o = ctrl_q[tmc_pkg::B_DPB];
	assign pingpong_active_o       = ctrl_q[tmc_pkg::B_PINGPONG_ACTIVE_FLAG];
	assign make_busy_o             = ctrl_q[tmc_pkg::B_BUSY];
endmodule
`default_nettype wire

// file: hw/tmc_irq.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_irq #(
	parameter int unsigned LOG_W = 8
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       arst_n_i,
	input  wire logic [tmc_pkg::NUM_EV-1:0] ev_i,
	input  wire logic                       stat_wr_i,
	input  wire logic                       mask_wr_i,
	input  wire logic [tmc_pkg::NUM_EV-1:0] wdata_i,
	output logic      [tmc_pkg::NUM_EV-1:0] status_o,
	output logic      [tmc_pkg::NUM_EV-1:0] mask_o,
	output logic      [LOG_W-1:0]           log_cnt_o,
	output logic      [tmc_pkg::NUM_EV-1:0] log_last_o,
	output logic                            irq_o
);
	localparam int N = tmc_pkg::NUM_EV;
	if (LOG_W < 1 || LOG_W > 16) begin : g_chk
		$error("tmc_irq: LOG_W out of range");
	end

	logic [N-1:0]     st_q, st_d, mk_q, mk_d, last_q, last_d;
	logic [LOG_W-1:0] cnt_q, cnt_d;

	// ------------------------------------------------------------
	// Sticky status, write one to clear; a new event wins
	// ------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_st
		always_comb begin
			st_d[i] = st_q[i];
			if (stat_wr_i && wdata_i[i]) begin
				st_d[i] = 1'b0;
			end
			if (ev_i[i]) begin
				st_d[i] = 1'b1;
			end
		end
	end

	// Mask and log: one entry per cycle that raises any event
	always_comb begin
		mk_d   = mask_wr_i ? wdata_i : mk_q;
		cnt_d  = (|ev_i) ? cnt_q + 1'b1 : cnt_q;
		last_d = (|ev_i) ? ev_i : last_q;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q   <= tmc_pkg::EV_RST;
			mk_q   <= tmc_pkg::EV_RST;
			last_q <= tmc_pkg::EV_RST;
			cnt_q  <= '0;
		end else begin
			st_q   <= st_d;
			mk_q   <= mk_d;
			last_q <= last_d;
			cnt_q  <= cnt_d;
		end
	end

	assign status_o   = st_q;
	assign mask_o     = mk_q;
	assign log_cnt_o  = cnt_q;
	assign log_last_o = last_q;
	assign irq_o      = |(st_q & mk_q);
endmodule
`default_nettype wire

// file: hw/tmc_pkg.sv
package tmc_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_CFG   = 8'h04;
	localparam logic [7:0] OFF_GEN   = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0c;
	localparam logic [7:0] OFF_MASK  = 8'h10;
	localparam logic [7:0] OFF_INDEX = 8'h14;
	localparam logic [7:0] OFF_LOG   = 8'h18;

	// ------------------------------------------------------------
	// Control word fields
	// ------------------------------------------------------------
	localparam int B_IXZ_EN = 15;
	localparam int B_ACC_EN = 14;
	localparam int B_BC_EN  = 13;
	localparam int B_BUSY   = 12;
	localparam int B_DESCRIPTOR_ACCESSED_FLAG   = 11;
	localparam int B_DPB    = 10;
	localparam int B_BROADCAST_SEEN_FLAG  = 9;
	localparam int B_PINGPONG_ACTIVE_FLAG   = 8;
	localparam int B_PINGPONG_SUSPEND_REQUEST  = 3;
	localparam int B_PINGPONG_SELECT   = 2;
	localparam logic [15:0] CTRL_RST       = 16'h0000;
	localparam logic [15:0] HOST_ANY_MASK  = 16'hf008;
	localparam logic [15:0] HOST_IDLE_MASK = 16'h0004;
	localparam logic [15:0] USED_MASK      = 16'hff0c;

	// ------------------------------------------------------------
	// Configuration and interrupt fields
	// ------------------------------------------------------------
	localparam int C_TFE  = 0;
	localparam int C_EXEC = 1;
	localparam int C_SIMPLIFIED_MODECODE_HANDLING = 2;
	localparam int C_SOFT_RESET_CMD = 3;
	localparam logic [2:0] CFG_RST = 3'h0;
	localparam int NUM_EV = 3;
	localparam int EV_IXZ = 0;
	localparam int EV_ACC = 1;
	localparam int EV_BC  = 2;
	localparam logic [2:0] EV_RST = 3'h0;

	// Mode code subaddresses
	localparam logic [4:0] SA_MC_LO = 5'h00;
	localparam logic [4:0] SA_MC_HI = 5'h1f;

	typedef enum logic [1:0] {
		TMC_MODE_INDEXED,
		TMC_MODE_PINGPONG,
		TMC_MODE_SIMPLE
	} tmc_mode_t;

endpackage

// file: hw/tmc_regbus_if.sv
`timescale 1ns/1ns
`default_nettype none
// Register strobes between the bus front end and the register bank
interface tmc_regbus_if;
	logic        wr;
	logic        rd;
	logic [7:0]  waddr;
	logic [7:0]  raddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport front (output wr, rd, waddr, raddr, wdata, input rdata);
	modport regs  (input wr, rd, waddr, raddr, wdata, output rdata);
endinterface
`default_nettype wire
